/* File: inc/lsi_pkg.sv */
package lsi_pkg;

	// channel count and lamp vector layout
	localparam int NUM_CHAN     = 4;
	localparam int NUM_LAMP     = 2 + 2 * NUM_CHAN;
	localparam int LAMP_POWER_G = 0;
	localparam int LAMP_POWER_Y = 1;
	localparam int LAMP_TRF_Y   = 2;   // channel c yellow at LAMP_TRF_Y + 2*c
	localparam int LAMP_TRF_R   = 3;   // channel c red at LAMP_TRF_R + 2*c

	// timing: clock rate and pattern times in milliseconds
	localparam int CLK_HZ        = 10_000_000;
	localparam int CYC_PER_MS    = CLK_HZ / 1000;
	localparam int SLOW_HALF_MS  = 500;
	localparam int FAST_HALF_MS  = 125;
	localparam int FLASH_MS      = 20;
	localparam int RUN_STEP_MS   = 250;
	localparam int SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
	localparam int FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
	localparam int FLASH_CYC     = FLASH_MS * CYC_PER_MS;
	localparam int RUN_STEP_CYC  = RUN_STEP_MS * CYC_PER_MS;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_OVR_SEL  = 8'h04;
	localparam logic [7:0] OFS_OVR_VAL  = 8'h08;
	localparam logic [7:0] OFS_STATE    = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_LAMPS    = 8'h18;

	// control fields
	localparam int CTRL_LAMP_TEST = 0;
	localparam int OVR_SEL_W      = 1 + NUM_CHAN;  // bit0 power lamp, bit 1+c traffic c

	// state register fields
	localparam int ST_CONFIGURED  = 0;
	localparam int ST_FW_UPDATE   = 1;
	localparam int ST_CFG_FAULT   = 2;
	localparam int ST_POWER_FAULT = 3;
	localparam int ST_OVERRUN     = 4;   // NUM_CHAN bits
	localparam int ST_ERR_PASS    = 8;   // NUM_CHAN bits

	// interrupt fields
	localparam int IRQ_W           = NUM_CHAN + 2;
	localparam int IRQ_OVERRUN     = 0;   // NUM_CHAN bits
	localparam int IRQ_CFG_FAULT   = 4;
	localparam int IRQ_POWER_FAULT = 5;

	// reset values
	localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
	localparam logic [31:0] RST_OVR_SEL  = 32'h0000_0000;
	localparam logic [31:0] RST_OVR_VAL  = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;

	// per-channel status from a CAN controller
	typedef struct packed {
		logic rx_frame;     // one-cycle pulse per received frame
		logic err_frame;    // one-cycle pulse per error frame
		logic err_passive;  // level
		logic overrun;      // one-cycle pulse on receive overrun
		logic bus_off;      // level
	} lsi_chan_status_type;

	// device-wide status from the usb side
	typedef struct packed {
		logic configured;
		logic fw_update;
		logic cfg_fault;
		logic power_fault;
	} lsi_dev_status_type;

endpackage

/* File: src/lsi_led_status.sv */
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ns
// Overview of operation
// - one traffic lamp per CAN channel plus one shared power lamp.
// - power lamp is green or yellow; traffic lamps are yellow or red.
// - device errors light all traffic lamps at once.
// - flash lights a lamp briefly per event; back-to-back flashes look steady.
// - slow blink toggles on and off with equal halves.
// - fast blink toggles faster than slow blink, equal halves.
// - slow waver shows second colour in the slow blink dark half.
// - running lights each colour in turn: power g, power y, then channels y, r.
// - configured and healthy: power lamp steady green.
// - unconfigured: power slow-blinks yellow, traffic lamps dark.
// - configuration fault: power waver green/yellow, traffic waver yellow/red.
// - power fault: power waver green/yellow, traffic slow blink yellow.
// - idle dark, yellow flash per frame, red flash per error frame.
// - firmware update: all traffic lamps fast-blink yellow together.
// - error-passive channel fast-blinks red.
// - overrun gives steady red until that channel goes bus-off.
// - software can override any lamp; no default program indication.
module lsi_led_status
	import lsi_pkg::*;
#(
	parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
	parameter int unsigned FAST_HALF = FAST_HALF_CYC,
	parameter int unsigned FLASH_LEN = FLASH_CYC,
	parameter int unsigned RUN_STEP  = RUN_STEP_CYC
)
(
	// clock and reset
	input  wire logic                                core_clk,
	input  wire logic                                rst,
	// apb slave
	input  wire logic [7:0]                          paddr,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	// status sources
	input  wire lsi_dev_status_type                  dev_status,
	input  wire lsi_chan_status_type [NUM_CHAN-1:0]  chan_status,
	// lamps
	output logic                                     power_lamp_green,
	output logic                                     power_lamp_yellow,
	output logic      [NUM_CHAN-1:0]                 traffic_yellow,
	output logic      [NUM_CHAN-1:0]                 traffic_red,
	// interrupt
	output logic                                     irq
);

	logic [31:0]          ctrl;
	logic [OVR_SEL_W-1:0] ovr_sel;
	logic [NUM_LAMP-1:0]  ovr_val;
	logic [IRQ_W-1:0]     irq_mask;
	logic [IRQ_W-1:0]     irq_stat;
	logic [IRQ_W-1:0]     irq_event;
	logic [NUM_CHAN-1:0]  overrun_hold;
	logic                 cfg_fault_prev;
	logic                 power_fault_prev;
	logic [31:0]          slow_cnt;
	logic                 slow_phase;
	logic [31:0]          fast_cnt;
	logic                 fast_phase;
	logic [31:0]          run_cnt;
	logic [3:0]           run_idx;
	logic [NUM_CHAN-1:0]  flash_on;
	logic [NUM_CHAN-1:0]  flash_red;
	logic [NUM_LAMP-1:0]  lamps;
	logic [NUM_LAMP-1:0]  next_lamps;
	logic [31:0]          next_rdata;
	logic                 next_err;
	logic                 acc_start;
	logic                 wr_done;
	logic                 rd_done;

	// apb: respond one cycle into the access phase, commit on the completing edge
	assign acc_start = psel & penable & ~pready;
	assign wr_done   = psel & penable & pready & pwrite;
	assign rd_done   = psel & penable & pready & ~pwrite;

	// read mux and unmapped decode
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		case (paddr)
			OFS_CTRL:     next_rdata = ctrl;
			OFS_OVR_SEL:  next_rdata[OVR_SEL_W-1:0] = ovr_sel;
			OFS_OVR_VAL:  next_rdata[NUM_LAMP-1:0] = ovr_val;
			OFS_STATE:
			begin
				next_rdata[ST_CONFIGURED]  = dev_status.configured;
				next_rdata[ST_FW_UPDATE]   = dev_status.fw_update;
				next_rdata[ST_CFG_FAULT]   = dev_status.cfg_fault;
				next_rdata[ST_POWER_FAULT] = dev_status.power_fault;
				next_rdata[ST_OVERRUN +: NUM_CHAN] = overrun_hold;
				for (int c = 0; c < NUM_CHAN; c++)
					next_rdata[ST_ERR_PASS + c] = chan_status[c].err_passive;
			end
			OFS_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
			OFS_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
			OFS_LAMPS:    next_rdata[NUM_LAMP-1:0] = lamps;
			default:      next_err = 1'b1;
		endcase
	end

	// apb answer registers; pready pulses for one cycle per access
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= acc_start;
			pslverr <= acc_start & next_err;
			if (acc_start & ~pwrite)
				prdata <= next_rdata;
		end
	end

	// writable registers; only the low bit of ctrl has an effect, the rest is scratch
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl     <= RST_CTRL;
			ovr_sel  <= RST_OVR_SEL[OVR_SEL_W-1:0];
			ovr_val  <= RST_OVR_VAL[NUM_LAMP-1:0];
			irq_mask <= RST_IRQ_MASK[IRQ_W-1:0];
		end
		else if (wr_done)
		begin
			case (paddr)
				OFS_CTRL:     ctrl <= pwdata;
				OFS_OVR_SEL:  ovr_sel <= pwdata[OVR_SEL_W-1:0];
				OFS_OVR_VAL:  ovr_val <= pwdata[NUM_LAMP-1:0];
				OFS_IRQ_MASK: irq_mask <= pwdata[IRQ_W-1:0];
				default:      ;
			endcase
		end
	end

	// interrupt events: overrun pulses and rising edges of the device faults
	always_comb
	begin
		irq_event = '0;
		for (int c = 0; c < NUM_CHAN; c++)
			irq_event[IRQ_OVERRUN + c] = chan_status[c].overrun;
		irq_event[IRQ_CFG_FAULT]   = dev_status.cfg_fault & ~cfg_fault_prev;
		irq_event[IRQ_POWER_FAULT] = dev_status.power_fault & ~power_fault_prev;
	end

	// sticky status; a read clears only the bits it returned, so a late event survives
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			irq_stat         <= '0;
			cfg_fault_prev   <= 1'b0;
			power_fault_prev <= 1'b0;
			irq              <= 1'b0;
		end
		else
		begin
			cfg_fault_prev   <= dev_status.cfg_fault;
			power_fault_prev <= dev_status.power_fault;
			if (rd_done && paddr == OFS_IRQ_STAT)
				irq_stat <= (irq_stat & ~prdata[IRQ_W-1:0]) | irq_event;
			else
				irq_stat <= irq_stat | irq_event;
			irq <= |(irq_stat & irq_mask);
		end
	end

	// overrun latch per channel, held until bus-off; a new overrun wins over the clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
			overrun_hold <= '0;
		else
		begin
			for (int c = 0; c < NUM_CHAN; c++)
			begin
				if (chan_status[c].overrun)
					overrun_hold[c] <= 1'b1;
				else if (chan_status[c].bus_off)
					overrun_hold[c] <= 1'b0;
			end
		end
	end

	// slow time base, equal halves
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			slow_cnt   <= 32'h0000_0000;
			slow_phase <= 1'b0;
		end
		else if (slow_cnt >= SLOW_HALF - 1)
		begin
			slow_cnt   <= 32'h0000_0000;
			slow_phase <= ~slow_phase;
		end
		else
			slow_cnt <= slow_cnt + 32'h0000_0001;
	end

	// fast time base, equal halves
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			fast_cnt   <= 32'h0000_0000;
			fast_phase <= 1'b0;
		end
		else if (fast_cnt >= FAST_HALF - 1)
		begin
			fast_cnt   <= 32'h0000_0000;
			fast_phase <= ~fast_phase;
		end
		else
			fast_cnt <= fast_cnt + 32'h0000_0001;
	end

	// running sequence step; restarts at power green whenever the lamp test is off
	always_ff @(posedge core_clk)
	begin
		if (rst || !ctrl[CTRL_LAMP_TEST])
		begin
			run_cnt <= 32'h0000_0000;
			run_idx <= 4'h0;
		end
		else if (run_cnt >= RUN_STEP - 1)
		begin
			run_cnt <= 32'h0000_0000;
			if (run_idx == 4'(NUM_LAMP - 1))
				run_idx <= 4'h0;
			else
				run_idx <= run_idx + 4'h1;
		end
		else
			run_cnt <= run_cnt + 32'h0000_0001;
	end

	// per-channel flash stretchers; a new frame restarts the interval so bursts look steady
	for (genvar c = 0; c < NUM_CHAN; c++)
	begin : g_flash
		logic [31:0] flash_cnt;

		always_ff @(posedge core_clk)
		begin
			if (rst)
			begin
				flash_cnt    <= 32'h0000_0000;
				flash_on[c]  <= 1'b0;
				flash_red[c] <= 1'b0;
			end
			else if (chan_status[c].rx_frame || chan_status[c].err_frame)
			begin
				flash_cnt    <= 32'h0000_0000;
				flash_on[c]  <= 1'b1;
				flash_red[c] <= chan_status[c].err_frame;
			end
			else if (flash_on[c])
			begin
				if (flash_cnt >= FLASH_LEN - 1)
					flash_on[c] <= 1'b0;
				else
					flash_cnt <= flash_cnt + 32'h0000_0001;
			end
		end
	end

	// lamp selection, highest priority last so it overwrites
	always_comb
	begin
		next_lamps = '0;
		// normal power lamp; one colour at a time since both colours share one package
		next_lamps[LAMP_POWER_G] = 1'b1;
		for (int c = 0; c < NUM_CHAN; c++)
		begin
			if (overrun_hold[c])
				next_lamps[LAMP_TRF_R + 2*c] = 1'b1;
			else if (chan_status[c].err_passive)
				next_lamps[LAMP_TRF_R + 2*c] = fast_phase;
			else if (flash_on[c])
			begin
				next_lamps[LAMP_TRF_R + 2*c] = flash_red[c];
				next_lamps[LAMP_TRF_Y + 2*c] = ~flash_red[c];
			end
		end
		// device-wide patterns replace all channel patterns
		if (dev_status.cfg_fault)
		begin
			next_lamps[LAMP_POWER_G] = slow_phase;
			next_lamps[LAMP_POWER_Y] = ~slow_phase;
			for (int c = 0; c < NUM_CHAN; c++)
			begin
				next_lamps[LAMP_TRF_Y + 2*c] = slow_phase;
				next_lamps[LAMP_TRF_R + 2*c] = ~slow_phase;
			end
		end
		else if (dev_status.power_fault)
		begin
			next_lamps[LAMP_POWER_G] = slow_phase;
			next_lamps[LAMP_POWER_Y] = ~slow_phase;
			for (int c = 0; c < NUM_CHAN; c++)
			begin
				next_lamps[LAMP_TRF_Y + 2*c] = slow_phase;
				next_lamps[LAMP_TRF_R + 2*c] = 1'b0;
			end
		end
		else if (!dev_status.configured)
		begin
			next_lamps[LAMP_POWER_G] = 1'b0;
			next_lamps[LAMP_POWER_Y] = slow_phase;
			for (int c = 0; c < NUM_CHAN; c++)
			begin
				next_lamps[LAMP_TRF_Y + 2*c] = 1'b0;
				next_lamps[LAMP_TRF_R + 2*c] = 1'b0;
			end
		end
		else if (dev_status.fw_update)
		begin
			for (int c = 0; c < NUM_CHAN; c++)
			begin
				next_lamps[LAMP_TRF_Y + 2*c] = fast_phase;
				next_lamps[LAMP_TRF_R + 2*c] = 1'b0;
			end
		end
		// software override, lamp by lamp
		if (ovr_sel[0])
		begin
			next_lamps[LAMP_POWER_G] = ovr_val[LAMP_POWER_G];
			next_lamps[LAMP_POWER_Y] = ovr_val[LAMP_POWER_Y];
		end
		for (int c = 0; c < NUM_CHAN; c++)
		begin
			if (ovr_sel[1 + c])
			begin
				next_lamps[LAMP_TRF_Y + 2*c] = ovr_val[LAMP_TRF_Y + 2*c];
				next_lamps[LAMP_TRF_R + 2*c] = ovr_val[LAMP_TRF_R + 2*c];
			end
		end
		// lamp test shows the running sequence over everything else
		if (ctrl[CTRL_LAMP_TEST])
		begin
			next_lamps = '0;
			next_lamps[run_idx] = 1'b1;
		end
	end

	// lamp registers; the mapping onto pins gives each channel its own dual lamp
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			lamps             <= '0;
			power_lamp_green  <= 1'b0;
			power_lamp_yellow <= 1'b0;
			traffic_yellow    <= '0;
			traffic_red       <= '0;
		end
		else
		begin
			lamps             <= next_lamps;
			power_lamp_green  <= next_lamps[LAMP_POWER_G];
			power_lamp_yellow <= next_lamps[LAMP_POWER_Y];
			for (int c = 0; c < NUM_CHAN; c++)
			begin
				traffic_yellow[c] <= next_lamps[LAMP_TRF_Y + 2*c];
				traffic_red[c]    <= next_lamps[LAMP_TRF_R + 2*c];
			end
		end
	end

endmodule // lsi_led_status

/* File: verif/lsi_led_status_asserts.sv */
`timescale 1ns/1ns
module lsi_led_status_asserts
	import lsi_pkg::*;
#(
	parameter int unsigned SLOW_HALF = SLOW_HALF_CYC
)
(
	// clock and reset
	input wire logic				core_clk,
	input wire logic				rst,
	// apb
	input wire logic [7:0]			paddr,
	input wire logic				psel,
	input wire logic				penable,
	input wire logic				pwrite,
	input wire logic [31:0]			pwdata,
	input wire logic				pready,
	// status
	input wire lsi_dev_status_type	dev_status,
	input wire lsi_chan_status_type [NUM_CHAN-1:0] chan_status,
	// lamps
	input wire logic				power_lamp_green,
	input wire logic				power_lamp_yellow,
	input wire logic [NUM_CHAN-1:0]	traffic_yellow,
	input wire logic [NUM_CHAN-1:0]	traffic_red
);
	logic					live, tst, ovr, quiet, y_d;
	logic [NUM_CHAN-1:0]	lat, lat_d;
	lsi_dev_status_type		dev_d;
	int						run, stab;
	wire					wr = psel && penable && pready && pwrite;
	wire					calm = live && quiet && dev_status == dev_d;
	wire					norm = calm && dev_status == 4'h8;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// software lamp control, one cycle late so it lines up with the lamp pipeline
	always_ff @(posedge core_clk)
	begin
		if (rst)
			{tst, ovr} <= 2'h0;
		else if (wr && paddr == OFS_CTRL)
			tst <= pwdata[CTRL_LAMP_TEST];
		else if (wr && paddr == OFS_OVR_SEL)
			ovr <= |pwdata[OVR_SEL_W-1:0];
		quiet <= !tst && !ovr;
	end
	// overrun latch per channel, a new overrun wins over bus-off
	always_ff @(posedge core_clk)
	begin
		for (int c = 0; c < NUM_CHAN; c++)
			lat[c] <= !rst && (chan_status[c].overrun || (lat[c] && !chan_status[c].bus_off));
		lat_d <= lat;
	end
	// run lengths; stab keeps the first partial half of a new mode out of the period check
	always_ff @(posedge core_clk)
	begin
		live <= !rst;
		dev_d <= dev_status;
		y_d <= power_lamp_yellow;
		run <= (power_lamp_yellow != y_d) ? 1 : run + 1;
		stab <= (rst || !calm) ? 0 : stab + 1;
	end

	a_unconf_dark: assert property (
		calm && dev_status == 4'h0 |-> !power_lamp_green && traffic_yellow == 4'h0 && traffic_red == 4'h0)
		else $error("lamp lit while unconfigured");
	a_slow_half: assert property (
		calm && dev_status == 4'h0 && stab > 3 * SLOW_HALF && power_lamp_yellow != y_d |-> run == SLOW_HALF)
		else $error("slow blink half has wrong length");
	a_healthy_green: assert property (
		norm |-> power_lamp_green && !power_lamp_yellow)
		else $error("power lamp not steady green");
	a_cfg_power: assert property (
		calm && dev_status.cfg_fault |-> power_lamp_green != power_lamp_yellow)
		else $error("power lamp not wavering on config fault");
	a_cfg_traffic: assert property (
		calm && dev_status.cfg_fault |-> (traffic_yellow ^ traffic_red) == 4'hf && traffic_red inside {4'h0, 4'hf})
		else $error("traffic lamps not wavering together");
	a_power_traffic: assert property (
		calm && dev_status == 4'h9 |-> traffic_red == 4'h0 && traffic_yellow inside {4'h0, 4'hf}
			&& power_lamp_green != power_lamp_yellow)
		else $error("power fault pattern wrong");
	a_fw_blink: assert property (
		calm && dev_status == 4'hc |-> traffic_red == 4'h0 && traffic_yellow inside {4'h0, 4'hf} && power_lamp_green)
		else $error("update pattern wrong");
	a_ovr_red: assert property (
		norm |-> (lat & lat_d & ~traffic_red) == 4'h0 && (lat & lat_d & traffic_yellow) == 4'h0)
		else $error("overrun channel not steady red");
endmodule // lsi_led_status_asserts

/* File: verif/lsi_lamp_model.sv */
`timescale 1ns/1ns
module lsi_lamp_model
	import lsi_pkg::*;
(
	// clock and count restart
	input wire logic				core_clk,
	input wire logic				clr,
	// lamp drive
	input wire logic				power_lamp_green,
	input wire logic				power_lamp_yellow,
	input wire logic [NUM_CHAN-1:0]	traffic_yellow,
	input wire logic [NUM_CHAN-1:0]	traffic_red,
	// lamp view
	output logic [NUM_LAMP-1:0]		lamp_vec,
	output int						lit_cnt [NUM_LAMP]
);
	// one shared two-colour power lamp, one two-colour lamp per channel
	always_comb
	begin
		lamp_vec[LAMP_POWER_G] = power_lamp_green;
		lamp_vec[LAMP_POWER_Y] = power_lamp_yellow;
		for (int c = 0; c < NUM_CHAN; c++)
		begin
			lamp_vec[LAMP_TRF_Y + 2 * c] = traffic_yellow[c];
			lamp_vec[LAMP_TRF_R + 2 * c] = traffic_red[c];
		end
	end
	// lit time per colour; an eye only sees duty, so patterns are judged by these sums
	always @(posedge core_clk)
		for (int i = 0; i < NUM_LAMP; i++)
			lit_cnt[i] <= clr ? 0 : lit_cnt[i] + lamp_vec[i];
endmodule // lsi_lamp_model

/* File: verif/lsi_led_status_tb_top.sv */
`timescale 1ns/1ns
module lsi_led_status_tb_top
	import lsi_pkg::*;
;
	localparam int SH = 20;
	localparam int FH = 6;
	localparam int FL = 4;
	localparam int RS = 5;
	logic								core_clk = 1'h0;
	logic								rst = 1'h1;
	logic [7:0]							paddr = 8'h00;
	logic								psel = 1'h0;
	logic								penable = 1'h0;
	logic								pwrite = 1'h0;
	logic [31:0]						pwdata = 32'h0;
	lsi_dev_status_type					dev_status = '0;
	lsi_chan_status_type [NUM_CHAN-1:0]	chan_status = '0;
	logic [31:0]						prdata;
	logic								pready, pslverr, irq, plg, ply, clr = 1'h1;
	logic [NUM_CHAN-1:0]				ty, tr;
	logic [NUM_LAMP-1:0]				lamp_vec;
	int									lit_cnt [NUM_LAMP];
	logic [32:0]						exp_q [$];
	int									n_fail = 0;
	int									num_checks = 0;
	integer								seed = 32'h63626868;
	logic [9:0]							v;
	int									e [NUM_LAMP];

	always #50 core_clk = ~core_clk;

	lsi_led_status #(.SLOW_HALF(SH), .FAST_HALF(FH), .FLASH_LEN(FL), .RUN_STEP(RS)) lsi_led_status_inst (
		.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_status(dev_status),
		.chan_status(chan_status), .power_lamp_green(plg), .power_lamp_yellow(ply), .traffic_yellow(ty),
		.traffic_red(tr), .irq(irq));
	lsi_lamp_model lsi_lamp_model_inst (.core_clk(core_clk), .clr(clr), .power_lamp_green(plg),
		.power_lamp_yellow(ply), .traffic_yellow(ty), .traffic_red(tr), .lamp_vec(lamp_vec), .lit_cnt(lit_cnt));

	task automatic check(input logic [32:0] got, input logic [32:0] want);
		num_checks++;
		if (got !== want)
		begin
			n_fail++;
			$display("BAD t=%0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one apb transfer; read expectations go to the queue for the monitor
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] ex);
		int k;
		@(posedge core_clk);
		{psel, paddr, pwrite, pwdata} <= {1'h1, a, w, d};
		@(posedge core_clk);
		penable <= 1'h1;
		if (!w)
			exp_q.push_back(ex);
		k = 0;
		do
			@(posedge core_clk);
		while (pready !== 1'h1 && ++k < 20);
		{psel, penable} <= 2'h0;
		if (k == 20)
		begin
			n_fail++;
			complete_run();
		end
	endtask
	task automatic pulse(input int c, input logic [4:0] p);
		@(posedge core_clk) chan_status[c] <= chan_status[c] | p;
		@(posedge core_clk) chan_status[c] <= chan_status[c] & ~p;
	endtask
	task automatic zero;
		@(posedge core_clk) clr <= 1'h1;
		@(posedge core_clk) clr <= 1'h0;
	endtask
	task automatic tally(input int n, input int ex [NUM_LAMP]);
		repeat (n) @(posedge core_clk);
		#1;
		for (int i = 0; i < NUM_LAMP; i++)
			check(lit_cnt[i], ex[i]);
	endtask

	// read answers are taken in order as pready shows them
	always @(posedge core_clk)
		if (psel && penable && pready && !pwrite)
			check({pslverr, prdata}, exp_q.pop_front());

	initial
	begin
		repeat (6) @(posedge core_clk);
		rst <= 1'h0;
		// reset values, read-only write and the unmapped place
		apb(OFS_STATE, 1'h1, 32'hffff_ffff, 33'h0);
		for (int a = 0; a < 8; a++)
			if (a != 6)
				apb(8'(a * 4), 1'h0, 32'h0, (a == 7) ? 33'h1_0000_0000 : 33'h0);
		apb(OFS_CTRL, 1'h1, 32'ha5a5_a5a4, 33'h0);
		apb(OFS_CTRL, 1'h0, 32'h0, 33'ha5a5_a5a4);
		zero();
		tally(6 * SH, '{0, 3 * SH, 0, 0, 0, 0, 0, 0, 0, 0});
		@(posedge core_clk) dev_status <= 4'h8;
		zero();
		tally(2 * SH, '{2 * SH, 0, 0, 0, 0, 0, 0, 0, 0, 0});
		// frame, error frame and both at once
		zero();
		pulse(0, 5'h10);
		pulse(1, 5'h08);
		pulse(2, 5'h18);
		tally(14, '{20, 0, FL, 0, 0, FL, 0, FL, 0, 0});
		// overrun beats a flash, error-passive blinks, interrupt raised, masked and cleared
		apb(OFS_IRQ_MASK, 1'h1, 32'h3f, 33'h0);
		@(posedge core_clk) chan_status[3].err_passive <= 1'h1;
		pulse(0, 5'h02);
		for (int k = 0; k < 20 && irq !== 1'h1; k++)
			@(posedge core_clk);
		check(irq, 1'h1);
		apb(OFS_STATE, 1'h0, 32'h0, 33'h811);
		apb(OFS_IRQ_STAT, 1'h0, 32'h0, 33'h01);
		zero();
		pulse(0, 5'h10);
		tally(46, '{48, 0, 0, 48, 0, 0, 0, 0, 0, 24});
		apb(OFS_IRQ_MASK, 1'h1, 32'h3e, 33'h0);
		pulse(0, 5'h02);
		repeat (3) @(posedge core_clk);
		check(irq, 1'h0);
		apb(OFS_IRQ_STAT, 1'h0, 32'h0, 33'h01);
		pulse(0, 5'h01);
		apb(OFS_STATE, 1'h0, 32'h0, 33'h801);
		// device-wide patterns over the channel ones
		@(posedge core_clk) dev_status <= 4'hc;
		zero();
		tally(8 * FH, '{48, 0, 24, 0, 24, 0, 24, 0, 24, 0});
		@(posedge core_clk) dev_status <= 4'h9;
		zero();
		tally(4 * SH, '{40, 40, 40, 0, 40, 0, 40, 0, 40, 0});
		apb(OFS_IRQ_STAT, 1'h0, 32'h0, 33'h20);
		@(posedge core_clk) dev_status <= 4'hb;
		zero();
		tally(4 * SH, '{default: 40});
		apb(OFS_IRQ_STAT, 1'h0, 32'h0, 33'h10);
		// software override of every lamp, then lamp test
		@(posedge core_clk) dev_status <= 4'h8;
		chan_status[3] <= '0;
		v = 10'($random(seed));
		apb(OFS_OVR_VAL, 1'h1, {22'h0, v}, 33'h0);
		apb(OFS_OVR_SEL, 1'h1, 32'h1f, 33'h0);
		apb(OFS_OVR_VAL, 1'h0, 32'h0, {23'h0, v});
		apb(OFS_LAMPS, 1'h0, 32'h0, {23'h0, v});
		for (int i = 0; i < NUM_LAMP; i++)
			e[i] = v[i] * 10;
		zero();
		tally(10, e);
		apb(OFS_OVR_SEL, 1'h1, 32'h0, 33'h0);
		apb(OFS_CTRL, 1'h1, 32'h1, 33'h0);
		zero();
		tally(10 * RS, '{default: RS});
		apb(OFS_CTRL, 1'h1, 32'h0, 33'h0);
		complete_run();
	end
endmodule // lsi_led_status_tb_top

bind lsi_led_status lsi_led_status_asserts #(.SLOW_HALF(SLOW_HALF)) lsi_led_status_asserts_inst (
	.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .pready(pready), .dev_status(dev_status), .chan_status(chan_status),
	.power_lamp_green(power_lamp_green), .power_lamp_yellow(power_lamp_yellow),
	.traffic_yellow(traffic_yellow), .traffic_red(traffic_red));
